// [pfc_buck_pwm.sv]
`timescale 1ns/1ps
module pfc_buck_pwm #(
  parameter int unsigned PERIOD = pfc_pkg::PWM_CYC,
  parameter int unsigned DEAD   = pfc_pkg::DEAD_CYC,
  parameter int unsigned CW     = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  input  wire logic          run,
  input  wire logic [CW-1:0] duty,
  output logic               high_drive,
  output logic               low_drive,
  output logic               period_end
);
  // ==========================================================
  // period counter
  logic [CW-1:0] cnt_r;
  logic [CW:0]   lo_start;

  if (PERIOD < 4 * DEAD + 2 || PERIOD >= 2 ** CW) begin : g_chk
    $error("pfc_buck_pwm: period does not fit the counter");
  end

  assign lo_start   = {1'b0, duty} + (CW+1)'(DEAD);
  assign period_end = (cnt_r == CW'(PERIOD - 1));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (period_end) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // ==========================================================
  // gate drives, dead time keeps both switches from conducting together
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_drive <= 1'b0;
      low_drive  <= 1'b0;
    end else begin
      high_drive <= run && cnt_r >= CW'(DEAD) && cnt_r < duty; // see [R07]
      low_drive  <= run && {1'b0, cnt_r} >= lo_start && cnt_r < CW'(PERIOD - DEAD);
    end
  end

  no_overlap_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see [R07]
    !(high_drive && low_drive)) else $error("buck drives overlap");
endmodule

// [pfc_fuse_ckt.sv]
`timescale 1ns/1ps
module pfc_fuse_ckt (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic fuse_blow_output,
  output logic      fuse_drive_active
);
  // ==========================================================
  // fuse driver: one cycle of lag stands in for its turn-on time
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse_drive_active <= 1'b0;
    end else begin
      fuse_drive_active <= fuse_blow_output;
    end
  end
endmodule

// [pfc_pkg.sv]
package pfc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned MS_TICK_CYC = CLK_HZ / MS_PER_S;
  localparam int unsigned GRACE_MS    = 500;
  localparam int unsigned TERM_S      = 40;
  localparam int unsigned TERM_MS     = TERM_S * MS_PER_S;
  localparam int unsigned PWM_HZ      = 1_000_000;
  localparam int unsigned PWM_CYC     = CLK_HZ / PWM_HZ;
  localparam int unsigned DEAD_CYC    = 1;
  // ==========================================================
  // register map
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATE    = 8'h01;
  localparam logic [7:0] A_LATCH    = 8'h02;
  localparam logic [7:0] A_CFG_BASE = 8'h03;
  localparam int unsigned CFG_N     = 10;
  localparam int unsigned CFG_FUSE_DLY = 0;
  localparam int unsigned CFG_PRE_I    = 1;
  localparam int unsigned CFG_CC_I     = 2;
  localparam int unsigned CFG_SYS_I    = 3;
  localparam int unsigned CFG_PRE_V    = 4;
  localparam int unsigned CFG_CELL_LIM = 5;
  localparam int unsigned CFG_TERM_WIN = 6;
  localparam int unsigned CFG_TAPER_I  = 7;
  localparam int unsigned CFG_HOST_V   = 8;
  localparam int unsigned CFG_HOST_I   = 9;
  localparam logic [7:0] CFG_RST [CFG_N] = '{8'h01, 8'h10, 8'h40, 8'h80, 8'h60,
                                             8'hD0, 8'hC8, 8'h08, 8'hC0, 8'h40};
  // ==========================================================
  // field positions
  localparam int unsigned CT_CHG_EN    = 0;
  localparam int unsigned CT_DSG_EN    = 1;
  localparam int unsigned CT_CHARGE_ON = 2;
  localparam int unsigned CT_ZERO_V    = 3;
  localparam int unsigned CT_HOST      = 4;
  localparam int unsigned CT_FUSE_FIRE = 5;
  localparam int unsigned ST_ADP_CTRL  = 0;
  localparam int unsigned ST_FUSE_RAW  = 1;
  localparam int unsigned ST_ADP_ON    = 2;
  localparam int unsigned ST_CHG_ON    = 3;
  localparam int unsigned ST_DSG_ON    = 4;
  localparam int unsigned ST_FAULT     = 5;
  localparam int unsigned LT_FUSE      = 0;
  localparam int unsigned LT_FUSE_OFF  = 1;
  localparam int unsigned LT_TERM      = 2;
  localparam int unsigned LT_STATE_LSB = 4;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  // ==========================================================
  // charge sequence
  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_PRE  = 3'b001,
    CS_CC   = 3'b010,
    CS_CV   = 3'b011,
    CS_DONE = 3'b100
  } pfc_chg_t;
endpackage

// [pfc_sequencer.sv]
// Overview of operation
// [R01] any safety fault drops both protection gates
// [R02] software clearing both enables drops both gates
// [R03] adapter gate needs comparator, control bit, conditions
// [R04] raw fuse drive readable, one means active
// [R05] fuse latches after delay, gates off 500 ms later
// [R06] weak pull-up while fuse output is low
// [R07] buck switches at one megahertz
// [R08] start current chosen from lowest cell voltage
// [R09] charger current capped at charge current value
// [R10] after termination cap becomes max system current
// [R11] highest cell at limit stops raising output voltage
// [R12] window plus low taper for 40 s terminates
// [R13] host values replace profile when override set
// [R14] zero-volt mode routes narrow output to charge gate
// [R15] clearing fuse flag in grace cancels shutdown
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module pfc_sequencer #(
  parameter int unsigned MS_TICK_CYC = pfc_pkg::MS_TICK_CYC,
  parameter int unsigned GRACE_MS    = pfc_pkg::GRACE_MS,
  parameter int unsigned TERM_MS     = pfc_pkg::TERM_MS
) (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       safety_fault,
  input  wire logic       adapter_above_sense,
  input  wire logic       adapter_ok,
  input  wire logic       fuse_drive_active,
  input  wire logic [7:0] cell_v_min,
  input  wire logic [7:0] cell_v_max,
  input  wire logic [7:0] batt_current,
  input  wire logic [7:0] chg_out_current,
  input  wire logic [7:0] chg_out_voltage,
  input  wire logic [7:0] profile_voltage,
  input  wire logic [7:0] profile_current,
  output logic            charge_path_gate,
  output logic            discharge_path_gate,
  output logic            adapter_input_gate,
  output logic            fuse_blow_output,
  output logic            fuse_weak_pullup,
  output logic            narrow_voltage_output_route,
  output logic            buck_high_drive,
  output logic            buck_low_drive,
  output logic      [7:0] charge_current_limit_value,
  output logic      [7:0] charge_voltage_target,
  output logic            charge_voltage_hold,
  output logic            charge_terminated
);
  localparam int unsigned MSW  = $clog2(MS_TICK_CYC + 1);
  localparam int unsigned TW   = 16;
  localparam int unsigned DCW  = 8;
  localparam int unsigned DMAX = pfc_pkg::PWM_CYC - 2 * pfc_pkg::DEAD_CYC;

  if (MS_TICK_CYC < 2 || GRACE_MS < 1 || GRACE_MS >= 2 ** TW ||
      TERM_MS < 1 || TERM_MS >= 2 ** TW) begin : g_chk
    $error("pfc_sequencer: count parameter out of range");
  end

  // ==========================================================
  // register port
  logic [7:0]       ctrl_r;
  logic             adp_ctrl_r;
  logic [7:0]       cfg_r [pfc_pkg::CFG_N];
  logic             fuse_latched_r;
  logic             fuse_off_r;
  logic             term_flag_r;
  pfc_pkg::pfc_chg_t state_r;
  pfc_pkg::pfc_chg_t state_nxt;
  logic [7:0]       rd_nxt;
  logic             wr_state;
  logic             wr_latch;
  logic [3:0]       cfg_idx;

  function automatic logic in_cfg(input logic [7:0] a);
    in_cfg = a >= pfc_pkg::A_CFG_BASE &&
             a < pfc_pkg::A_CFG_BASE + 8'(pfc_pkg::CFG_N);
  endfunction

  assign cfg_idx  = 4'(reg_addr - pfc_pkg::A_CFG_BASE);
  assign wr_state = reg_wr && reg_addr == pfc_pkg::A_STATE;
  assign wr_latch = reg_wr && reg_addr == pfc_pkg::A_LATCH;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= pfc_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == pfc_pkg::A_CTRL) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      adp_ctrl_r <= 1'b0;
    end else if (wr_state) begin
      adp_ctrl_r <= reg_wdata[pfc_pkg::ST_ADP_CTRL];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= pfc_pkg::CFG_RST;
    end else if (reg_wr && in_cfg(reg_addr)) begin
      cfg_r[cfg_idx] <= reg_wdata;
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    rd_nxt = 8'h00;
    if (reg_addr == pfc_pkg::A_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (reg_addr == pfc_pkg::A_STATE) begin
      rd_nxt[pfc_pkg::ST_ADP_CTRL] = adp_ctrl_r;
      rd_nxt[pfc_pkg::ST_FUSE_RAW] = fuse_drive_active; // see [R04]
      rd_nxt[pfc_pkg::ST_ADP_ON]   = adapter_input_gate;
      rd_nxt[pfc_pkg::ST_CHG_ON]   = charge_path_gate;
      rd_nxt[pfc_pkg::ST_DSG_ON]   = discharge_path_gate;
      rd_nxt[pfc_pkg::ST_FAULT]    = safety_fault;
    end else if (reg_addr == pfc_pkg::A_LATCH) begin
      rd_nxt[pfc_pkg::LT_FUSE]     = fuse_latched_r;
      rd_nxt[pfc_pkg::LT_FUSE_OFF] = fuse_off_r;
      rd_nxt[pfc_pkg::LT_TERM]     = term_flag_r;
      rd_nxt[pfc_pkg::LT_STATE_LSB +: 3] = state_r;
    end else if (in_cfg(reg_addr)) begin
      rd_nxt = cfg_r[cfg_idx];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // millisecond tick
  logic [MSW-1:0] ms_cnt_r;
  logic           ms_tick;

  assign ms_tick = (ms_cnt_r == MSW'(MS_TICK_CYC - 1));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_r <= '0;
    end else if (ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + MSW'(1);
    end
  end

  // ==========================================================
  // fuse supervision
  logic [TW-1:0] raw_ms_r;
  logic [TW-1:0] grace_ms_r;
  logic          fuse_set;
  logic          fuse_clr;

  assign fuse_set = fuse_drive_active &&
                    raw_ms_r >= TW'(cfg_r[pfc_pkg::CFG_FUSE_DLY]);
  assign fuse_clr = wr_latch && reg_wdata[pfc_pkg::LT_FUSE];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_ms_r <= '0;
    end else if (!fuse_drive_active) begin
      raw_ms_r <= '0;
    end else if (ms_tick && raw_ms_r != '1) begin
      raw_ms_r <= raw_ms_r + TW'(1);
    end
  end

  // a new latch event outranks a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse_latched_r <= 1'b0;
    end else if (fuse_set) begin
      fuse_latched_r <= 1'b1; // see [R05]
    end else if (fuse_clr) begin
      fuse_latched_r <= 1'b0; // see [R15]
    end
  end

  // grace timer restarts from zero whenever the flag drops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      grace_ms_r <= '0;
    end else if (!fuse_latched_r) begin
      grace_ms_r <= '0; // see [R15]
    end else if (ms_tick && grace_ms_r != TW'(GRACE_MS)) begin
      grace_ms_r <= grace_ms_r + TW'(1);
    end
  end

  // shutdown is permanent until reset, as a blown pack would be
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse_off_r <= 1'b0;
    end else if (fuse_latched_r && grace_ms_r == TW'(GRACE_MS)) begin
      fuse_off_r <= 1'b1; // see [R05]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse_blow_output <= 1'b0;
      fuse_weak_pullup <= 1'b1;
    end else begin
      fuse_blow_output <= ctrl_r[pfc_pkg::CT_FUSE_FIRE];
      fuse_weak_pullup <= !ctrl_r[pfc_pkg::CT_FUSE_FIRE]; // see [R06]
    end
  end

  // ==========================================================
  // charge sequence
  logic [TW-1:0] taper_ms_r;
  logic          taper_ok;
  logic          chg_req;
  logic          pwm_end;
  logic [7:0]    v_tgt;
  logic [7:0]    i_cc;

  assign chg_req  = ctrl_r[pfc_pkg::CT_CHARGE_ON] && !safety_fault && !fuse_off_r;
  assign taper_ok = state_r == pfc_pkg::CS_CV &&
                    cell_v_max >= cfg_r[pfc_pkg::CFG_TERM_WIN] &&
                    batt_current < cfg_r[pfc_pkg::CFG_TAPER_I];
  // host values win over the profile on the next cycle, no smoothing
  assign v_tgt = ctrl_r[pfc_pkg::CT_HOST] ? cfg_r[pfc_pkg::CFG_HOST_V]
                                          : profile_voltage; // see [R13]
  assign i_cc  = ctrl_r[pfc_pkg::CT_HOST] ? cfg_r[pfc_pkg::CFG_HOST_I]
                                          : profile_current; // see [R13]

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      taper_ms_r <= '0;
    end else if (!taper_ok) begin
      taper_ms_r <= '0;
    end else if (ms_tick && taper_ms_r != TW'(TERM_MS)) begin
      taper_ms_r <= taper_ms_r + TW'(1); // see [R12]
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pfc_pkg::CS_IDLE: begin
        if (chg_req) begin
          state_nxt = (cell_v_min < cfg_r[pfc_pkg::CFG_PRE_V]) ? pfc_pkg::CS_PRE
                                                               : pfc_pkg::CS_CC; // see [R08]
        end
      end
      pfc_pkg::CS_PRE: begin
        if (cell_v_min >= cfg_r[pfc_pkg::CFG_PRE_V]) begin
          state_nxt = pfc_pkg::CS_CC;
        end
      end
      pfc_pkg::CS_CC: begin
        if (cell_v_max >= cfg_r[pfc_pkg::CFG_CELL_LIM]) begin
          state_nxt = pfc_pkg::CS_CV; // see [R11]
        end
      end
      pfc_pkg::CS_CV: begin
        if (taper_ms_r == TW'(TERM_MS)) begin
          state_nxt = pfc_pkg::CS_DONE; // see [R12]
        end
      end
      pfc_pkg::CS_DONE: state_nxt = pfc_pkg::CS_DONE;
      default: state_nxt = pfc_pkg::CS_IDLE;
    endcase
    if (!chg_req) begin
      state_nxt = pfc_pkg::CS_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= pfc_pkg::CS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      term_flag_r <= 1'b0;
    end else if (state_nxt == pfc_pkg::CS_DONE && state_r == pfc_pkg::CS_CV) begin
      term_flag_r <= 1'b1; // see [R12]
    end else if (wr_latch && reg_wdata[pfc_pkg::LT_TERM]) begin
      term_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_current_limit_value <= 8'h00;
      charge_voltage_target      <= 8'h00;
      charge_voltage_hold        <= 1'b0;
      charge_terminated          <= 1'b0;
    end else begin
      case (state_nxt)
        pfc_pkg::CS_PRE:  charge_current_limit_value <= cfg_r[pfc_pkg::CFG_PRE_I];
        pfc_pkg::CS_DONE: charge_current_limit_value <= cfg_r[pfc_pkg::CFG_SYS_I]; // see [R10]
        pfc_pkg::CS_IDLE: charge_current_limit_value <= 8'h00;
        default:          charge_current_limit_value <= i_cc; // see [R09]
      endcase
      charge_voltage_target <= v_tgt;
      charge_voltage_hold   <= state_nxt == pfc_pkg::CS_CV; // see [R11]
      charge_terminated     <= state_nxt == pfc_pkg::CS_DONE;
    end
  end

  // ==========================================================
  // protection and adapter gates
  logic gate_chg;
  logic zero_v_pre;

  assign gate_chg   = ctrl_r[pfc_pkg::CT_CHG_EN] && !safety_fault && !fuse_off_r;
  assign zero_v_pre = ctrl_r[pfc_pkg::CT_ZERO_V] && state_nxt == pfc_pkg::CS_PRE;

  // gates follow the fault on the next edge, not a software round trip
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_path_gate    <= 1'b0;
      discharge_path_gate <= 1'b0;
      narrow_voltage_output_route          <= 1'b0;
    end else begin
      charge_path_gate    <= gate_chg && !zero_v_pre &&
                             state_nxt != pfc_pkg::CS_DONE; // see [R01] [R02] [R05] [R12]
      discharge_path_gate <= ctrl_r[pfc_pkg::CT_DSG_EN] && !safety_fault &&
                             !fuse_off_r; // see [R01] [R02] [R05]
      narrow_voltage_output_route          <= gate_chg && zero_v_pre; // see [R14]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      adapter_input_gate <= 1'b0;
    end else begin
      adapter_input_gate <= adp_ctrl_r && adapter_above_sense && adapter_ok &&
                            !safety_fault; // see [R03]
    end
  end

  // ==========================================================
  // buck regulation: one duty step per switching period
  logic [DCW-1:0] duty_r;
  logic           pwm_run;
  logic           i_over;
  logic           v_over;

  assign pwm_run = state_r != pfc_pkg::CS_IDLE && adapter_input_gate;
  assign i_over  = chg_out_current > charge_current_limit_value;
  assign v_over  = chg_out_voltage > charge_voltage_target;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      duty_r <= '0;
    end else if (!pwm_run) begin
      duty_r <= '0;
    end else if (pwm_end) begin
      if ((i_over || v_over) && duty_r != '0) begin
        duty_r <= duty_r - DCW'(1); // see [R09]
      end else if (!i_over && !v_over && !charge_voltage_hold &&
                   chg_out_current != charge_current_limit_value &&
                   duty_r < DCW'(DMAX)) begin
        duty_r <= duty_r + DCW'(1); // see [R11]
      end
    end
  end

  pfc_buck_pwm #(
    .PERIOD (pfc_pkg::PWM_CYC),
    .DEAD   (pfc_pkg::DEAD_CYC),
    .CW     (DCW)
  ) u_pwm (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .run        (pwm_run),
    .duty       (duty_r),
    .high_drive (buck_high_drive),
    .low_drive  (buck_low_drive),
    .period_end (pwm_end)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  fault_gates_off_a: assert property (safety_fault |=> // see [R01]
    !charge_path_gate && !discharge_path_gate) else $error("gate on after fault");
  sw_gates_off_a: assert property ( // see [R02]
    !ctrl_r[pfc_pkg::CT_CHG_EN] && !ctrl_r[pfc_pkg::CT_DSG_EN] |=>
    !charge_path_gate && !discharge_path_gate) else $error("gate on while disabled");
  adapter_gate_a: assert property (adapter_input_gate |-> // see [R03]
    $past(adp_ctrl_r && adapter_above_sense && adapter_ok))
    else $error("adapter gate without its conditions");
  fuse_raw_read_a: assert property (reg_rd && reg_addr == pfc_pkg::A_STATE |=> // see [R04]
    reg_rdata[pfc_pkg::ST_FUSE_RAW] == $past(fuse_drive_active))
    else $error("raw fuse readback wrong");
  fuse_shutdown_a: assert property ($rose(fuse_off_r) |-> // see [R05]
    $past(fuse_latched_r) && $past(grace_ms_r) == TW'(GRACE_MS))
    else $error("shutdown before grace expiry");
  fuse_grace_a: assert property (fuse_off_r |=> // see [R05]
    !charge_path_gate && !discharge_path_gate) else $error("gate on after fuse");
  pullup_low_a: assert property (!fuse_blow_output && $past(!fuse_blow_output) |-> // see [R06]
    fuse_weak_pullup) else $error("no pull-up while fuse output low");
  start_pre_a: assert property (state_r == pfc_pkg::CS_IDLE && chg_req && // see [R08]
    cell_v_min < cfg_r[pfc_pkg::CFG_PRE_V] |=> state_r == pfc_pkg::CS_PRE)
    else $error("precharge not chosen");
  done_limit_a: assert property (state_r == pfc_pkg::CS_DONE |-> // see [R10]
    charge_current_limit_value == cfg_r[pfc_pkg::CFG_SYS_I] || $changed(cfg_r[pfc_pkg::CFG_SYS_I]))
    else $error("system limit not applied");
  cv_hold_a: assert property (state_r == pfc_pkg::CS_CV |=> // see [R11]
    $past(duty_r) >= duty_r || !$past(pwm_run)) else $error("duty raised in hold");
  term_time_a: assert property ($rose(charge_terminated) |-> // see [R12]
    $past(taper_ms_r) == TW'(TERM_MS)) else $error("early termination");
  host_value_a: assert property (ctrl_r[pfc_pkg::CT_HOST] |=> // see [R13]
    charge_voltage_target == $past(cfg_r[pfc_pkg::CFG_HOST_V])) else $error("host value ignored");
  route_a: assert property (narrow_voltage_output_route |-> !charge_path_gate && // see [R14]
    state_r == pfc_pkg::CS_PRE) else $error("route outside zero-volt precharge");
  clear_cancel_a: assert property (fuse_clr && !fuse_set |=> // see [R15]
    !fuse_latched_r ##1 !fuse_off_r || $past(fuse_off_r)) else $error("clear not honoured");

  reach_done_c:  cover property (state_r == pfc_pkg::CS_CV ##1 state_r == pfc_pkg::CS_DONE);
  fuse_off_c:    cover property ($rose(fuse_off_r));
  fuse_cancel_c: cover property (fuse_latched_r ##1 !fuse_latched_r);
  precharge_c:   cover property (state_r == pfc_pkg::CS_PRE ##1 state_r == pfc_pkg::CS_CC);
endmodule

// [pfc_sequencer_test.sv]
`timescale 1ns/1ps
module pfc_sequencer_test;
  logic       sys_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, lim, vtgt;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, flt = 1'b0, above = 1'b0, aok = 1'b0;
  logic [7:0] v_min = 8'h20, v_max = 8'h80, i_bat = 8'h20;
  logic [7:0] i_chg = 8'h08, v_chg = 8'h90, p_v = 8'hA0, p_i = 8'h33;
  logic       cg, dg, ag, fo, pu, nv, bh, bl, hold, term, fact;
  int         fails = 0;
  int         n_tests = 0;
  realtime    t0;
  always #12.5 sys_clk = ~sys_clk;
  // ==========================================================
  // design and far side
  pfc_sequencer #(.MS_TICK_CYC(4), .GRACE_MS(5), .TERM_MS(8)) u_pfc_sequencer (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .safety_fault(flt),
    .adapter_above_sense(above), .adapter_ok(aok), .fuse_drive_active(fact),
    .cell_v_min(v_min), .cell_v_max(v_max), .batt_current(i_bat),
    .chg_out_current(i_chg), .chg_out_voltage(v_chg), .profile_voltage(p_v),
    .profile_current(p_i), .charge_path_gate(cg), .discharge_path_gate(dg),
    .adapter_input_gate(ag), .fuse_blow_output(fo), .fuse_weak_pullup(pu),
    .narrow_voltage_output_route(nv), .buck_high_drive(bh), .buck_low_drive(bl),
    .charge_current_limit_value(lim), .charge_voltage_target(vtgt),
    .charge_voltage_hold(hold), .charge_terminated(term));
  pfc_fuse_ckt u_pfc_fuse_ckt (
    .sys_clk(sys_clk), .arst_n(arst_n), .fuse_blow_output(fo), .fuse_drive_active(fact));
  // ==========================================================
  // access and compare tasks
  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata & m, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // ==========================================================
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    fails++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdc(8'h00, 8'hFF, 8'h00);
    rdc(8'h0D, 8'hFF, 8'h00);
    rdc(8'h03, 8'hFF, 8'h01);
    wr(8'h00, 8'h03);
    cyc(2);
    chk({6'h00, cg, dg}, 8'h03);
    @(posedge sys_clk) flt <= 1'b1;
    cyc(2);
    chk({6'h00, cg, dg}, 8'h00);
    rdc(8'h01, 8'h38, 8'h20);
    @(posedge sys_clk) flt <= 1'b0;
    cyc(2);
    chk({6'h00, cg, dg}, 8'h03);
    wr(8'h00, 8'h00);
    cyc(2);
    chk({6'h00, cg, dg}, 8'h00);
    @(posedge sys_clk) above <= 1'b1;
    aok <= 1'b1;
    cyc(2);
    chk({7'h00, ag}, 8'h00);
    wr(8'h01, 8'h01);
    cyc(2);
    chk({7'h00, ag}, 8'h01);
    @(posedge sys_clk) above <= 1'b0;
    cyc(2);
    chk({7'h00, ag}, 8'h00);
    @(posedge sys_clk) above <= 1'b1;
    // charge run from a low cell, zero-volt routing on
    wr(8'h00, 8'h0D);
    cyc(2);
    chk(lim, 8'h10);
    rdc(8'h02, 8'h70, 8'h10);
    chk({6'h00, nv, cg}, 8'h02);
    // output current sits below the limit, so duty climbs and the high side pulses
    cyc(200);
    @(posedge bh) t0 = $realtime;
    @(posedge bh) chk(8'(int'(($realtime - t0) / 25.0)), 8'h28);
    @(posedge bl) #1 chk({6'h00, bh, bl}, 8'h01);
    wr(8'h00, 8'h05);
    @(posedge sys_clk) v_min <= 8'h70;
    cyc(3);
    chk(lim, 8'h33);
    chk(vtgt, 8'hA0);
    wr(8'h00, 8'h15);
    cyc(2);
    chk(lim, 8'h40);
    chk(vtgt, 8'hC0);
    @(posedge sys_clk) v_max <= 8'hD0;
    cyc(3);
    chk({7'h00, hold}, 8'h01);
    @(posedge sys_clk) i_bat <= 8'h04;
    cyc(45);
    chk({6'h00, term, cg}, 8'h02);
    chk(lim, 8'h80);
    rdc(8'h02, 8'h74, 8'h44);
    // fuse: cleared in grace first, then left to shut the gates
    wr(8'h00, 8'h23);
    cyc(3);
    chk({7'h00, pu}, 8'h00);
    rdc(8'h01, 8'h02, 8'h02);
    cyc(4);
    rdc(8'h02, 8'h01, 8'h01);
    wr(8'h00, 8'h03);
    // let the raw drive fall first, a latch event beats a clear in one cycle
    cyc(2);
    wr(8'h02, 8'h01);
    cyc(30);
    rdc(8'h02, 8'h03, 8'h00);
    chk({6'h00, cg, dg}, 8'h03);
    chk({7'h00, pu}, 8'h01);
    wr(8'h00, 8'h23);
    cyc(45);
    chk({6'h00, cg, dg}, 8'h00);
    rdc(8'h02, 8'h02, 8'h02);
    wrap_up;
  end
endmodule
